// ==== dv/reg_file_model.sv ====
// Register file model standing in for the general-purpose registers.
// Assumes the bench reads it by hierarchy to find operand values.
module reg_file_model;
  timeunit 1ns;
  timeprecision 1ns;

  logic [31:0] gpr [0:7];

  // Preset register contents
  initial
  begin
    gpr[0] = 32'h0000_0000;
    gpr[1] = 32'h7fff_ffff;
    gpr[2] = 32'h0000_0001;
    gpr[3] = 32'hffff_ffff;
    gpr[4] = 32'h1234_5681;
    gpr[5] = 32'hf0f0_ff00;
    gpr[6] = 32'h8000_0000;
    gpr[7] = 32'h0ff0_0ff0;
  end
endmodule : reg_file_model

// ==== dv/testbench.sv ====
// Self-checking bench for the add, logic and assert unit over APB.
// Assumes the register map and opcodes of alu_exec_regs.svh.
`include "alu_exec_regs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys    = 1'b0;
  logic        sys_rst    = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] q;
  logic        err;
  int          fails      = 0;
  int          n_compared = 0;
  int          cycles     = 0;

  reg_file_model i_rf();

  alu_exec i_dut
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq)
  );

  // Clock, 50 ns period
  always #25 clk_sys = ~clk_sys;

  // Cut a hang short
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Execute one instruction and compare result (not for asserts), flags and trap outcome
  task automatic run(input logic [7:0] op, input logic [7:0] rc, input logic [2:0] ra,
                     input logic [7:0] rb, input logic cin, input logic usr);
    logic [31:0] a;
    logic [31:0] b;
    logic [32:0] s;
    logic [31:0] r;
    logic        v;
    a = i_rf.gpr[ra];
    b = op[0] ? {24'h00_0000, rb} : i_rf.gpr[rb[2:0]];
    s = {1'b0, a} + {1'b0, b} + {32'h0, op[3] & cin};
    r = (op[7:4] == 4'h1) ? s[31:0] : (op[3] ? a & ~b : a & b);
    v = (a[31] == b[31]) && (r[31] != a[31]);
    apb(1'b1, `OFS_CTRL, {31'h0, usr});
    apb(1'b1, `OFS_FLAGS, {31'h0, cin});
    apb(1'b1, `OFS_OPA, a);
    apb(1'b1, `OFS_OPB, i_rf.gpr[rb[2:0]]);
    apb(1'b1, `OFS_INSTR, {op, rc, 5'h00, ra, rb});
    apb(1'b0, `OFS_TRAP, 32'h0);
    if (op[7:4] == 4'h1)
    begin
      check(q, {1'b1, 7'h00, rc, 15'h0000, op[1] ? s[32] : v});
      apb(1'b0, `OFS_FLAGS, 32'h0);
      check(q, {28'h0, v, r[31], r == 32'h0, s[32]});
    end
    else if (op[7:4] == 4'h9)
    begin
      check(q, {1'b1, 7'h00, rc, 16'h0000});
      apb(1'b0, `OFS_FLAGS, 32'h0);
      check(q, {28'h0, 1'b0, r[31], r == 32'h0, cin});
    end
    else
    begin
      check(q, (a == b) ? 32'h0 : {16'h0000, rc, 5'h00, (usr && rc < 8'h40) ? 3'b100 : 3'b010});
      apb(1'b0, `OFS_FLAGS, 32'h0);
      check(q, {31'h0, cin});
    end
    if (op[7:4] != 4'h7)
    begin
      apb(1'b0, `OFS_RESULT, 32'h0);
      check(q, r);
    end
  endtask : run

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 4; i < 9; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(q, 32'h0);
    end
    apb(1'b0, 8'hfc, 32'h0);
    check(q, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test reset and map done");
    run(8'h10, 8'h05, 3'd1, 8'h02, 1'b1, 1'b0);
    run(8'h10, 8'h05, 3'd6, 8'h06, 1'b0, 1'b0);
    run(8'h11, 8'h05, 3'd5, 8'h81, 1'b0, 1'b0);
    run(8'h12, 8'h05, 3'd3, 8'h02, 1'b0, 1'b0);
    run(8'h12, 8'h05, 3'd1, 8'h02, 1'b1, 1'b0);
    run(8'h13, 8'h05, 3'd6, 8'hff, 1'b1, 1'b0);
    run(8'h18, 8'h05, 3'd1, 8'h00, 1'b1, 1'b0);
    run(8'h19, 8'h05, 3'd6, 8'hff, 1'b1, 1'b0);
    run(8'h1a, 8'h05, 3'd3, 8'h00, 1'b1, 1'b0);
    run(8'h1b, 8'h05, 3'd7, 8'h10, 1'b1, 1'b0);
    $display("test add_signed_op done");
    run(8'h90, 8'h05, 3'd5, 8'h07, 1'b0, 1'b0);
    run(8'h91, 8'h05, 3'd3, 8'h81, 1'b1, 1'b0);
    run(8'h9c, 8'h05, 3'd3, 8'h07, 1'b1, 1'b0);
    run(8'h9d, 8'h05, 3'd6, 8'h00, 1'b0, 1'b0);
    $display("test logic done");
    run(8'h70, 8'h80, 3'd4, 8'h04, 1'b0, 1'b0);
    run(8'h70, 8'h80, 3'd4, 8'h03, 1'b1, 1'b0);
    run(8'h71, 8'h10, 3'd2, 8'h01, 1'b0, 1'b1);
    run(8'h70, 8'h10, 3'd4, 8'h03, 1'b0, 1'b1);
    run(8'h71, 8'h3f, 3'd2, 8'h02, 1'b0, 1'b1);
    run(8'h70, 8'h40, 3'd4, 8'h03, 1'b0, 1'b1);
    $display("test assert done");
    apb(1'b0, `OFS_STAT, 32'h0);
    apb(1'b1, `OFS_MASK, 32'h0000_0002);
    run(8'h90, 8'h05, 3'd5, 8'h07, 1'b0, 1'b0);
    check({31'h0, irq}, 32'h0);
    run(8'h10, 8'h05, 3'd1, 8'h02, 1'b0, 1'b0);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, `OFS_STAT, 32'h0);
    check(q, 32'h0000_0003);
    apb(1'b0, `OFS_STAT, 32'h0);
    check({q[30:0], irq}, 32'h0);
    $display("test interrupt done");
    // Unknown opcode: no result, illegal status bit
    apb(1'b1, `OFS_INSTR, 32'h0005_0000);
    apb(1'b0, `OFS_TRAP, 32'h0);
    check(q, 32'h0);
    apb(1'b0, `OFS_STAT, 32'h0);
    check(q, 32'h0000_0011);
    // Failing assert raises the interrupt when unmasked
    apb(1'b1, `OFS_MASK, 32'h0000_000c);
    run(8'h70, 8'h80, 3'd4, 8'h03, 1'b0, 1'b0);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, `OFS_STAT, 32'h0);
    check(q, 32'h0000_0005);
    $display("test decode done");
    report_and_stop();
  end
endmodule : testbench

// ==== hw/alu_exec.sv ====
// Integer add, logic and assert execution unit with APB register access.
// Software loads operand values, then writes an instruction word, which
// executes at once; result, flags and trap outcome are read back.
// Assumes a single 20 MHz clock and an APB master following the protocol.
`include "alu_exec_regs.svh"

module alu_exec
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  logic [31:0]          ctrl_q, ctrl_d;
  logic [31:0]          opa_q, opa_d;
  logic [31:0]          opb_q, opb_d;
  logic [31:0]          instr_q, instr_d;
  logic [31:0]          result_q, result_d;
  alu_exec_pkg::flags_s flags_q, flags_d;
  alu_exec_pkg::trap_s  trap_q, trap_d;
  logic [`IRQ_W-1:0]    stat_q, stat_d, mask_q, mask_d, ev_set;
  logic [31:0]          prdata_q, prdata_d;
  logic                 pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;

  logic                 setup, acc, fire, mapped;
  logic [7:0]           opc, base;
  logic                 imm;
  logic [31:0]          opb_x;
  logic [32:0]          sum;
  logic                 cin, sovf;
  alu_exec_pkg::op_kind_e kind;
  logic                 is_signed, is_carry_op;

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

  // Bus phase decode
  assign setup = psel & ~penable;
  assign acc   = psel & penable & pready_q;
  assign fire  = acc & pwrite & (paddr == `OFS_INSTR);

  // Instruction fields
  assign opc  = pwdata[31:24];
  assign imm  = opc[0];
  assign base = {opc[7:1], 1'b0};

  assign opb_x = imm ? {24'h000000, pwdata[7:0]} : opb_q;

  // Opcode classification
  always_comb
  begin
    is_signed   = 1'b0;
    is_carry_op = 1'b0;
    case (base)
      `OPC_ADD_SIGNED:       kind = alu_exec_pkg::K_ADD;
      `OPC_ADD_UNSIGNED:     kind = alu_exec_pkg::K_ADD;
      `OPC_ADD_CARRY_SIGNED: kind = alu_exec_pkg::K_ADD;
      `OPC_ADD_CARRY_UNSIGN: kind = alu_exec_pkg::K_ADD;
      `OPC_AND:              kind = alu_exec_pkg::K_AND;
      `OPC_AND_NOT:          kind = alu_exec_pkg::K_AND_NOT_OP;
      `OPC_ASSERT_EQUAL:     kind = alu_exec_pkg::K_ASSERT_EQUAL_OP;
      default:               kind = alu_exec_pkg::K_ILL;
    endcase
    if (base == `OPC_ADD_SIGNED || base == `OPC_ADD_CARRY_SIGNED)
    begin
      is_signed = 1'b1;
    end
    if (base == `OPC_ADD_CARRY_SIGNED || base == `OPC_ADD_CARRY_UNSIGN)
    begin
      is_carry_op = 1'b1;
    end
  end

  assign cin  = is_carry_op & flags_q.c;
  assign sum  = {1'b0, opa_q} + {1'b0, opb_x} + {32'h00000000, cin};
  assign sovf = (opa_q[31] == opb_x[31]) & (sum[31] != opa_q[31]);

  // Instruction execution next state
  always_comb
  begin
    result_d = result_q;
    flags_d  = flags_q;
    trap_d   = trap_q;
    instr_d  = instr_q;
    ev_set   = '0;
    if (fire)
    begin
      instr_d        = pwdata;
      trap_d         = '0;
      trap_d.target  = pwdata[23:16];
      ev_set[`IRQ_DONE] = 1'b1;
      case (kind)
        alu_exec_pkg::K_ADD:
        begin
          result_d       = sum[31:0];
          trap_d.written = 1'b1;
          flags_d.v = sovf;
          flags_d.n = sum[31];
          flags_d.z = (sum[31:0] == 32'h00000000);
          flags_d.c = sum[32];
          trap_d.oor = is_signed ? sovf : sum[32];
        end
        alu_exec_pkg::K_AND:
        begin
          result_d       = opa_q & opb_x;
          trap_d.written = 1'b1;
          flags_d.n      = result_d[31];
          flags_d.z      = (result_d == 32'h00000000);
        end
        alu_exec_pkg::K_AND_NOT_OP:
        begin
          result_d       = opa_q & ~opb_x;
          trap_d.written = 1'b1;
          flags_d.n      = result_d[31];
          flags_d.z      = (result_d == 32'h00000000);
        end
        alu_exec_pkg::K_ASSERT_EQUAL_OP:
        begin
          trap_d.target = 8'h00;
          if (opa_q != opb_x)
          begin
            trap_d.vector = pwdata[23:16];
            if (ctrl_q[0] && pwdata[23:16] <= `PROT_VEC_MAX)
            begin
              trap_d.prot = 1'b1;
            end
            else
            begin
              trap_d.asrt = 1'b1;
            end
          end
        end
        default:
        begin
          trap_d.target = 8'h00;
        end
      endcase
      ev_set[`IRQ_OOR]  = trap_d.oor;
      ev_set[`IRQ_ASRT] = trap_d.asrt;
      ev_set[`IRQ_PROT] = trap_d.prot;
      ev_set[`IRQ_ILL]  = (kind == alu_exec_pkg::K_ILL);
    end
  end

  // Software writable registers and read path
  always_comb
  begin
    ctrl_d    = ctrl_q;
    opa_d     = opa_q;
    opb_d     = opb_q;
    mask_d    = mask_q;
    prdata_d  = prdata_q;
    pready_d  = setup;
    pslverr_d = 1'b0;
    mapped    = 1'b1;
    if (paddr == `OFS_CTRL)
      prdata_d = {31'h00000000, ctrl_q[0]};
    else if (paddr == `OFS_OPA)
      prdata_d = opa_q;
    else if (paddr == `OFS_OPB)
      prdata_d = opb_q;
    else if (paddr == `OFS_INSTR)
      prdata_d = instr_q;
    else if (paddr == `OFS_RESULT)
      prdata_d = result_q;
    else if (paddr == `OFS_FLAGS)
      prdata_d = {28'h0000000, flags_q};
    else if (paddr == `OFS_TRAP)
      prdata_d = trap_q;
    else if (paddr == `OFS_STAT)
      prdata_d = {27'h0000000, stat_q};
    else if (paddr == `OFS_MASK)
      prdata_d = {27'h0000000, mask_q};
    else
    begin
      prdata_d = 32'h00000000;
      mapped   = 1'b0;
    end
    if (!setup)
      prdata_d = prdata_q;
    pslverr_d = setup & ~mapped;
    if (acc && pwrite)
    begin
      if (paddr == `OFS_CTRL)
        ctrl_d = {31'h00000000, pwdata[0]};
      else if (paddr == `OFS_OPA)
        opa_d = pwdata;
      else if (paddr == `OFS_OPB)
        opb_d = pwdata;
      else if (paddr == `OFS_MASK)
        mask_d = pwdata[`IRQ_W-1:0];
    end
  end

  // Flags register also software writable, a bus write has priority over execution
  alu_exec_pkg::flags_s flags_n;
  always_comb
  begin
    flags_n = flags_d;
    if (acc && pwrite && paddr == `OFS_FLAGS)
      flags_n = pwdata[3:0];
  end

  // Sticky status per bit; a set beats the read clear
  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_W; gi++)
    begin : g_stat
      always_comb
      begin
        stat_d[gi] = stat_q[gi];
        if (acc && !pwrite && paddr == `OFS_STAT && prdata_q[gi])
          stat_d[gi] = 1'b0;
        if (ev_set[gi])
          stat_d[gi] = 1'b1;
      end
    end
  endgenerate

  assign irq_d = |(stat_d & mask_d);

  // State registers
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q    <= `RST_WORD;
      opa_q     <= `RST_WORD;
      opb_q     <= `RST_WORD;
      instr_q   <= `RST_WORD;
      result_q  <= `RST_WORD;
      flags_q   <= `RST_FLAGS;
      trap_q    <= `RST_WORD;
      stat_q    <= `RST_IRQ;
      mask_q    <= `RST_IRQ;
      prdata_q  <= `RST_WORD;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q     <= 1'b0;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      opa_q     <= opa_d;
      opb_q     <= opb_d;
      instr_q   <= instr_d;
      result_q  <= result_d;
      flags_q   <= flags_n;
      trap_q    <= trap_d;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q     <= irq_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_add_fire;
    fire && kind == alu_exec_pkg::K_ADD;
  endsequence

  sequence s_assert_equal_op_fail;
    fire && kind == alu_exec_pkg::K_ASSERT_EQUAL_OP && opa_q != opb_x;
  endsequence

  property p_carry_sum;
    s_add_fire and is_carry_op |=> result_q == $past(opa_q) + $past(opb_x) + {31'h0, $past(flags_q.c)};
  endproperty
  a_carry_sum: assert property (p_carry_sum) else $error("carry add sum wrong");

  property p_plain_sum;
    s_add_fire and !is_carry_op |=> result_q == $past(opa_q) + $past(opb_x);
  endproperty
  a_plain_sum: assert property (p_plain_sum) else $error("plain add sum wrong");

  property p_signed_trap;
    s_add_fire and is_signed |=> trap_q.oor == ($past(opa_q[31]) == $past(opb_x[31]) && result_q[31] != $past(opa_q[31]));
  endproperty
  a_signed_trap: assert property (p_signed_trap) else $error("signed overflow trap wrong");

  property p_unsigned_trap;
    s_add_fire and !is_signed |=> trap_q.oor == (result_q < $past(opa_q) || (result_q == $past(opa_q) && $past(cin)))
      ##1 (stat_q[`IRQ_OOR] || !trap_q.oor);
  endproperty
  a_unsigned_trap: assert property (p_unsigned_trap) else $error("unsigned overflow trap wrong");

  property p_written;
    s_add_fire |=> trap_q.written && trap_q.target == $past(pwdata[23:16]);
  endproperty
  a_written: assert property (p_written) else $error("add target not written");

  property p_flags;
    s_add_fire |=> flags_q.z == (result_q == 32'h0) && flags_q.n == result_q[31] && flags_q.v == trap_q.oor | !$past(is_signed);
  endproperty
  a_flags: assert property (p_flags) else $error("add flags wrong");

  property p_imm_and;
    fire && kind == alu_exec_pkg::K_AND && imm |=> result_q == ($past(opa_q) & {24'h0, $past(pwdata[7:0])});
  endproperty
  a_imm_and: assert property (p_imm_and) else $error("immediate operand wrong");

  property p_and_not_op;
    fire && kind == alu_exec_pkg::K_AND_NOT_OP && !imm |=> result_q == ($past(opa_q) & ~$past(opb_q));
  endproperty
  a_and_not_op: assert property (p_and_not_op) else $error("and-not result wrong");

  property p_assert_equal_op;
    s_assert_equal_op_fail |=> (trap_q.asrt ^ trap_q.prot) && trap_q.vector == $past(pwdata[23:16]) && $stable(flags_q);
  endproperty
  a_assert_equal_op: assert property (p_assert_equal_op) else $error("assert trap wrong");

  property p_prot;
    s_assert_equal_op_fail and ctrl_q[0] && pwdata[23:16] <= `PROT_VEC_MAX |=> trap_q.prot && !trap_q.asrt;
  endproperty
  a_prot: assert property (p_prot) else $error("protection trap missing");

endmodule : alu_exec

// ==== pkg/alu_exec_pkg.sv ====
// Types shared by the integer add, logic and assert unit.
// Assumes the constants of alu_exec_regs.svh.
package alu_exec_pkg;

  // Arithmetic status flags
  typedef struct packed {
    logic v;
    logic n;
    logic z;
    logic c;
  } flags_s;

  // Outcome of the last executed instruction, one bus word
  typedef struct packed {
    logic       written;
    logic [6:0] pad_hi;
    logic [7:0] target;
    logic [7:0] vector;
    logic [4:0] pad_lo;
    logic       prot;
    logic       asrt;
    logic       oor;
  } trap_s;

  // Instruction class, one-hot
  typedef enum logic [4:0] {
    K_ADD  = 5'h01,
    K_AND  = 5'h02,
    K_AND_NOT_OP = 5'h04,
    K_ASSERT_EQUAL_OP = 5'h08,
    K_ILL  = 5'h10
  } op_kind_e;

endpackage : alu_exec_pkg

// ==== pkg/alu_exec_regs.svh ====
// Register offsets, field positions, reset values and opcodes of the
// integer add, logic and assert unit.
// Assumes an APB master with byte addresses on paddr[7:0].
//
// Function
// - An add with carry writes first operand plus second operand plus the carry flag to the target.
// - A plain add writes first operand plus second operand to the target, ignoring the carry flag.
// - Signed add_signed_op, with or without carry, raise an out-of-range trap on two's-complement overflow.
// - Unsigned add_signed_op, with or without carry, raise an out-of-range trap on a carry out of bit 31.
// - Every add writes its sum to the target even when it traps.
// - Every add updates the overflow, negative, zero and carry flags from its result.
// - The immediate bit picks the second operand: register value when clear, zero-extended low byte when set.
// - Opcode 1a is the unsigned add with carry from registers and 1b its immediate form.
// - The AND instruction writes the bitwise AND of both operands to the target.
// - The AND-NOT instruction writes the first operand ANDed with the inverted second operand.
// - Opcode 18 is the signed add with carry, trapping out of range on signed overflow.
// - The equality assert continues on equal operands, else traps to its vector, flags untouched.
// - A failing assert in user mode with vector 0 to 63 raises a protection violation instead.
`ifndef ALU_EXEC_REGS_SVH
`define ALU_EXEC_REGS_SVH

// Register byte offsets
`define OFS_CTRL   8'h00
`define OFS_OPA    8'h04
`define OFS_OPB    8'h08
`define OFS_INSTR  8'h0c
`define OFS_RESULT 8'h10
`define OFS_FLAGS  8'h14
`define OFS_TRAP   8'h18
`define OFS_STAT   8'h1c
`define OFS_MASK   8'h20

// Opcodes, register forms; bit 0 set gives the immediate form
`define OPC_ADD_SIGNED       8'h10
`define OPC_ADD_UNSIGNED     8'h12
`define OPC_ADD_CARRY_SIGNED 8'h18
`define OPC_ADD_CARRY_UNSIGN 8'h1a
`define OPC_AND              8'h90
`define OPC_AND_NOT          8'h9c
`define OPC_ASSERT_EQUAL     8'h70

// Interrupt status bit positions
`define IRQ_DONE  0
`define IRQ_OOR   1
`define IRQ_ASRT  2
`define IRQ_PROT  3
`define IRQ_ILL   4
`define IRQ_W     5

// Highest vector reserved to supervisor code
`define PROT_VEC_MAX 8'h3f

// Reset values
`define RST_WORD  32'h0000_0000
`define RST_FLAGS 4'h0
`define RST_IRQ   5'h00

`endif
